// *** logic/mtsc_stats.sv ***
// traffic statistics counter bank with classic wishbone slave
//
// Overview of operation
// - octets transmitted kept as 64 bits, read as low and high words
// - reading low word snapshots high word for the following high read
// - octet counter saturates at all ones instead of wrapping
// - every sent frame adds destination address through crc bytes
// - partially sent frames, like collided ones, add no octets
// - transmit counters move only while transmission is enabled
// - received frames counted only while reception is enabled
// - filter-rejected broadcast frames still counted; other rejected ones not
// - total sent frames counts each complete frame, pause frames included
// - total sent frames includes secure, sideband and management-generated frames
// - multicast sent counter excludes pause frames, needs transmit enable
// - broadcast sent counter counts standard and secure frames, transmit enabled
// - segmentation context counted once when its last piece is buffered
// - segmentation context counts need transmit and offload enabled
// - interrupt counter counts every interrupt assertion
// - event counters 32-bit, octet counter 64-bit; all read-only, reset to zero
`timescale 1ns/1ns
module mtsc_stats
import mtsc_pkg::*;
#(
   parameter int OCT_W = 64
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [MTSC_AW-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire mtsc_tx_evt_t tx_evt_i,
   input wire mtsc_rx_evt_t rx_evt_i,
   input wire logic seg_ctx_last_i,
   input wire logic irq_assert_i,
   output logic tx_en_o,
   output logic rx_en_o,
   output logic tso_en_o
);
   logic [2:0] ctrl_q;
   logic tx_en;
   logic rx_en;
   logic tso_en;
   logic tx_ok;
   logic oct_inc;
   logic [OCT_W-1:0] oct_cnt;
   logic [31:0] oct_hi_snap_q;
   logic [MTSC_NUM_CNT-1:0] cnt_inc;
   logic [31:0] cnt_val [MTSC_NUM_CNT];
   logic [31:0] rd_data_d;
   logic [31:0] dat_q;
   logic ack_q;
   logic req;
   logic rd_lo;
   mtsc_bus_st_t st_q;

   function automatic logic hit(input logic [MTSC_AW-1:0] a, input logic [15:0] ofs);
      hit = (a[MTSC_AW-1:2] == ofs[MTSC_AW-1:2]);
   endfunction

   assign tx_en = ctrl_q[MTSC_CTRL_TX_EN_BIT];
   assign rx_en = ctrl_q[MTSC_CTRL_RX_EN_BIT];
   assign tso_en = ctrl_q[MTSC_CTRL_TSO_EN_BIT];
   assign tx_en_o = tx_en;
   assign rx_en_o = rx_en;
   assign tso_en_o = tso_en;

   // a frame only counts once it has gone out whole
   assign tx_ok = tx_evt_i.done && tx_evt_i.complete && tx_en;
   assign oct_inc = tx_ok;

   mtsc_sat_counter #(
      .WIDTH(OCT_W),
      .INC_W(MTSC_LEN_W)
   ) u_oct (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .inc_i(oct_inc),
      .amount_i(tx_evt_i.len),
      .count_o(oct_cnt)
   );

   always_comb
   begin
      cnt_inc = '0;
      // rejected frames drop out unless they are broadcast
      cnt_inc[MTSC_IDX_RX_ALL] = rx_evt_i.done && rx_en
                                 && (!rx_evt_i.filt_reject || rx_evt_i.bcast);
      cnt_inc[MTSC_IDX_TX_ALL] = tx_ok;
      cnt_inc[MTSC_IDX_TX_GROUP] = tx_ok && tx_evt_i.group && !tx_evt_i.pause;
      cnt_inc[MTSC_IDX_TX_BCAST] = tx_ok && tx_evt_i.bcast;
      cnt_inc[MTSC_IDX_SEG_CTX] = seg_ctx_last_i && tx_en && tso_en;
      cnt_inc[MTSC_IDX_IRQ] = irq_assert_i;
   end

   // event counters wrap; only the octet pair is specified to saturate
   genvar gi;
   generate
      for (gi = 0; gi < MTSC_NUM_CNT; gi++)
      begin : g_cnt
         logic [31:0] c_q;
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
               c_q <= MTSC_CNT_RESET;
            else if (cnt_inc[gi])
               c_q <= c_q + 32'h0000_0001;
         end
         assign cnt_val[gi] = c_q;
      end
   endgenerate

   assign req = cyc_i && stb_i && !ack_q;
   assign rd_lo = req && !we_i && hit(adr_i, MTSC_OFS_TX_OCT_LO);

   // high word is frozen at low read so the pair stays coherent
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         oct_hi_snap_q <= MTSC_CNT_RESET;
      else if (rd_lo)
         oct_hi_snap_q <= oct_cnt[63:32];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ctrl_q <= MTSC_CTRL_RESET;
      else if (req && we_i && sel_i[0] && hit(adr_i, MTSC_OFS_CTRL))
         ctrl_q <= dat_i[2:0];
   end

   always_comb
   begin
      rd_data_d = MTSC_UNMAPPED_DATA;
      if (hit(adr_i, MTSC_OFS_TX_OCT_LO))
         rd_data_d = oct_cnt[31:0];
      else if (hit(adr_i, MTSC_OFS_TX_OCT_HI))
         rd_data_d = oct_hi_snap_q;
      else if (hit(adr_i, MTSC_OFS_RX_ALL))
         rd_data_d = cnt_val[MTSC_IDX_RX_ALL];
      else if (hit(adr_i, MTSC_OFS_TX_ALL))
         rd_data_d = cnt_val[MTSC_IDX_TX_ALL];
      else if (hit(adr_i, MTSC_OFS_TX_GROUP))
         rd_data_d = cnt_val[MTSC_IDX_TX_GROUP];
      else if (hit(adr_i, MTSC_OFS_TX_BCAST))
         rd_data_d = cnt_val[MTSC_IDX_TX_BCAST];
      else if (hit(adr_i, MTSC_OFS_SEG_CTX))
         rd_data_d = cnt_val[MTSC_IDX_SEG_CTX];
      else if (hit(adr_i, MTSC_OFS_IRQ))
         rd_data_d = cnt_val[MTSC_IDX_IRQ];
      else if (hit(adr_i, MTSC_OFS_CTRL))
         rd_data_d = {29'h0000_0000, ctrl_q};
   end

   // one-cycle answer, ack drops the cycle after; writes to counters ignored
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_q <= MTSC_BUS_IDLE;
         ack_q <= 1'b0;
         dat_q <= MTSC_UNMAPPED_DATA;
      end
      else
      begin
         case (st_q)
            MTSC_BUS_IDLE:
            begin
               ack_q <= req;
               if (req)
               begin
                  st_q <= MTSC_BUS_ACK;
                  dat_q <= we_i ? MTSC_UNMAPPED_DATA : rd_data_d;
               end
            end
            MTSC_BUS_ACK:
            begin
               ack_q <= 1'b0;
               st_q <= MTSC_BUS_IDLE;
            end
            default:
            begin
               ack_q <= 1'b0;
               st_q <= MTSC_BUS_IDLE;
            end
         endcase
      end
   end

   assign ack_o = ack_q;
   assign dat_o = dat_q;
endmodule

// *** logic/mtsc_pkg.sv ***
// package for the traffic statistics counter bank
package mtsc_pkg;
   localparam int MTSC_AW = 16;
   localparam logic [15:0] MTSC_OFS_TX_OCT_LO = 16'h40C8;
   localparam logic [15:0] MTSC_OFS_TX_OCT_HI = 16'h40CC;
   localparam logic [15:0] MTSC_OFS_RX_ALL = 16'h40D0;
   localparam logic [15:0] MTSC_OFS_TX_ALL = 16'h40D4;
   localparam logic [15:0] MTSC_OFS_TX_GROUP = 16'h40F0;
   localparam logic [15:0] MTSC_OFS_TX_BCAST = 16'h40F4;
   localparam logic [15:0] MTSC_OFS_SEG_CTX = 16'h40F8;
   localparam logic [15:0] MTSC_OFS_IRQ = 16'h4100;
   localparam logic [15:0] MTSC_OFS_CTRL = 16'h4110;
   localparam int MTSC_CTRL_TX_EN_BIT = 0;
   localparam int MTSC_CTRL_RX_EN_BIT = 1;
   localparam int MTSC_CTRL_TSO_EN_BIT = 2;
   localparam logic [31:0] MTSC_CNT_RESET = 32'h0000_0000;
   localparam logic [2:0] MTSC_CTRL_RESET = 3'h0;
   localparam logic [31:0] MTSC_UNMAPPED_DATA = 32'h0000_0000;
   localparam int MTSC_LEN_W = 16;
   localparam int MTSC_NUM_CNT = 6;
   localparam int MTSC_IDX_RX_ALL = 0;
   localparam int MTSC_IDX_TX_ALL = 1;
   localparam int MTSC_IDX_TX_GROUP = 2;
   localparam int MTSC_IDX_TX_BCAST = 3;
   localparam int MTSC_IDX_SEG_CTX = 4;
   localparam int MTSC_IDX_IRQ = 5;

   typedef struct packed {
      logic done;
      logic complete;
      logic group;
      logic bcast;
      logic pause;
      logic [MTSC_LEN_W-1:0] len;
   } mtsc_tx_evt_t;

   typedef struct packed {
      logic done;
      logic filt_reject;
      logic bcast;
   } mtsc_rx_evt_t;

   typedef enum logic [1:0] {
      MTSC_BUS_IDLE = 2'b00,
      MTSC_BUS_ACK = 2'b01
   } mtsc_bus_st_t;
endpackage

// *** logic/mtsc_sat_counter.sv ***
// saturating counter with enable gate and increment amount
`timescale 1ns/1ns
module mtsc_sat_counter
#(
   parameter int WIDTH = 32,
   parameter int INC_W = 16
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic inc_i,
   input wire logic [INC_W-1:0] amount_i,
   output logic [WIDTH-1:0] count_o
);
   logic [WIDTH-1:0] count_q;
   logic [WIDTH:0] sum_d;

   always_comb
   begin
      sum_d = {1'b0, count_q} + {{(WIDTH+1-INC_W){1'b0}}, amount_i};
   end

   // clamp instead of wrapping so software never sees a small value after overflow
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         count_q <= '0;
      else if (inc_i)
      begin
         if (sum_d[WIDTH])
            count_q <= '1;
         else
            count_q <= sum_d[WIDTH-1:0];
      end
   end

   assign count_o = count_q;
endmodule

// *** test/mtsc_stats_monitor.sv ***
// port checker for the statistics counter bank
`timescale 1ns/1ns
module mtsc_stats_monitor
import mtsc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [MTSC_AW-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic tx_en_o,
   input wire logic rx_en_o,
   input wire logic tso_en_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic take;
   logic ctl;
   assign take = cyc_i && stb_i && !ack_o;
   assign ctl = take && we_i && sel_i[0] && adr_i[15:2] == MTSC_OFS_CTRL[15:2];
   ack_resp_a:
      assert property (take |=> ack_o) else $error("request not answered");
   ack_pulse_a:
      assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
   ack_cause_a:
      assert property (!take |=> !ack_o) else $error("ack without request");
   wr_data_a:
      assert property (ack_o && $past(we_i) |-> dat_o == MTSC_CNT_RESET)
         else $error("write returned data");
   tx_gate_a:
      assert property (ctl |=> ##1 tx_en_o == $past(dat_i[MTSC_CTRL_TX_EN_BIT], 2))
         else $error("tx enable not written");
   rx_gate_a:
      assert property (ctl |=> ##1 rx_en_o == $past(dat_i[MTSC_CTRL_RX_EN_BIT], 2))
         else $error("rx enable not written");
   tso_gate_a:
      assert property (ctl |=> ##1 tso_en_o == $past(dat_i[MTSC_CTRL_TSO_EN_BIT], 2))
         else $error("offload enable not written");
   gate_hold_a:
      assert property ($changed({tx_en_o, rx_en_o, tso_en_o}) |-> $past(ctl) || $past(ctl, 2))
         else $error("enable moved without write");
   reset_val_a:
      assert property ($fell(rst_i) |-> !tx_en_o && !rx_en_o && !tso_en_o && !ack_o && dat_o == 0)
         else $error("bad state after reset");
   rd_c: cover property (take && !we_i);
   ctl_c: cover property (ctl);
   tx_on_c: cover property (tx_en_o && tso_en_o);
endmodule
bind mtsc_stats mtsc_stats_monitor mtsc_stats_monitor_i (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
   .dat_o(dat_o), .ack_o(ack_o), .tx_en_o(tx_en_o), .rx_en_o(rx_en_o), .tso_en_o(tso_en_o));

// *** test/mtsc_stats_tb_top.sv ***
// self-checking bench for the statistics counter bank
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module mtsc_stats_tb_top import mtsc_pkg::*;;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [15:0] adr_i = 16'h0;
   logic [3:0] sel_i = 4'hF;
   logic [31:0] dat_i = 32'h0;
   mtsc_tx_evt_t tx_evt_i = '0;
   mtsc_rx_evt_t rx_evt_i = '0;
   logic seg_i = 1'b0;
   logic irq_i = 1'b0;
   logic [31:0] dat_o;
   logic ack_o, tx_en_o, rx_en_o, tso_en_o;
   logic [31:0] q;
   int errors = 0;
   int tests_run = 0;
   int cycles = 0;
   logic [15:0] regs [8] = '{MTSC_OFS_TX_OCT_LO, MTSC_OFS_TX_OCT_HI, MTSC_OFS_RX_ALL,
      MTSC_OFS_TX_ALL, MTSC_OFS_TX_GROUP, MTSC_OFS_TX_BCAST, MTSC_OFS_SEG_CTX, MTSC_OFS_IRQ};
   mtsc_stats mtsc_stats_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .tx_evt_i(tx_evt_i), .rx_evt_i(rx_evt_i), .seg_ctx_last_i(seg_i), .irq_assert_i(irq_i),
      .tx_en_o(tx_en_o), .rx_en_o(rx_en_o), .tso_en_o(tso_en_o));
   initial forever #20 clk_i = ~clk_i;
   task automatic stop_test();
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // wait on ack with no cycle count assumed; the watchdog cuts a hang
   task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      // look between edges so ack and data are settled, then act on the edge that samples ack
      @(negedge clk_i);
      while (ack_o !== 1'b1) @(negedge clk_i);
      q = dat_o;
      @(posedge clk_i);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      `CHK(q, e)
   endtask
   task automatic ev(input mtsc_tx_evt_t t, input mtsc_rx_evt_t r, input logic s, input logic i);
      @(posedge clk_i);
      tx_evt_i <= t;
      rx_evt_i <= r;
      seg_i <= s;
      irq_i <= i;
      @(posedge clk_i);
      tx_evt_i <= '0;
      rx_evt_i <= '0;
      seg_i <= 1'b0;
      irq_i <= 1'b0;
   endtask
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 80000)
      begin
         errors++;
         stop_test();
      end
   end
   initial
   begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (regs[k]) rd(regs[k], 32'h0);
      rd(16'h4104, 32'h0);
      // all enables still off: only the interrupt counter may move
      ev('{1, 1, 1, 0, 0, 16'h40}, '{1, 0, 0}, 1'b1, 1'b1);
      rd(MTSC_OFS_TX_ALL, 32'h0);
      rd(MTSC_OFS_TX_OCT_LO, 32'h0);
      rd(MTSC_OFS_RX_ALL, 32'h0);
      rd(MTSC_OFS_SEG_CTX, 32'h0);
      rd(MTSC_OFS_IRQ, 32'h1);
      wb(1'b1, MTSC_OFS_CTRL, 32'h1);
      ev('{1, 1, 1, 0, 0, 16'h40}, '{1, 0, 0}, 1'b1, 1'b0);
      ev('{1, 1, 0, 1, 0, 16'h64}, '0, 1'b0, 1'b0);
      ev('{1, 1, 1, 0, 1, 16'h40}, '0, 1'b0, 1'b0);
      ev('{1, 0, 0, 0, 0, 16'h32}, '0, 1'b0, 1'b0);
      rd(MTSC_OFS_TX_OCT_LO, 32'h0000_00E4);
      rd(MTSC_OFS_TX_OCT_HI, 32'h0);
      rd(MTSC_OFS_TX_ALL, 32'h3);
      rd(MTSC_OFS_TX_GROUP, 32'h1);
      rd(MTSC_OFS_TX_BCAST, 32'h1);
      rd(MTSC_OFS_RX_ALL, 32'h0);
      rd(MTSC_OFS_SEG_CTX, 32'h0);
      wb(1'b1, MTSC_OFS_TX_ALL, 32'hFFFF_FFFF);
      rd(MTSC_OFS_TX_ALL, 32'h3);
      wb(1'b1, MTSC_OFS_CTRL, 32'h7);
      ev('0, '{1, 0, 0}, 1'b1, 1'b1);
      ev('0, '{1, 1, 1}, 1'b0, 1'b0);
      ev('0, '{1, 1, 0}, 1'b0, 1'b0);
      rd(MTSC_OFS_RX_ALL, 32'h2);
      rd(MTSC_OFS_SEG_CTX, 32'h1);
      rd(MTSC_OFS_IRQ, 32'h2);
      // back-to-back maximum frames carry the octet count past 32 bits
      @(posedge clk_i);
      tx_evt_i <= '{1, 1, 0, 0, 0, 16'hFFFF};
      repeat (65538) @(posedge clk_i);
      tx_evt_i <= '0;
      rd(MTSC_OFS_TX_OCT_HI, 32'h0);
      rd(MTSC_OFS_TX_OCT_LO, 32'h0001_00E2);
      rd(MTSC_OFS_TX_OCT_HI, 32'h1);
      rd(MTSC_OFS_TX_ALL, 32'h0001_0005);
      stop_test();
   end
endmodule
